// file: rtl/eip_top.sv
// External pin interrupt unit: three pins, sense control, masks,
// sticky flags, interrupt requests and level wake-up from power-down.
// Assumes a 200 MHz clock, a synchronous active-low reset, and a core
// that pulses irq_ack for the channel whose routine it enters.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Requests come from the pin level, so driving the pin as output interrupts.
// - Sense codes: 00 low, 01 any change, 10 falling, 11 rising.
// - Enabled level-sensed channel requests while its pin is low, outside power-down and start-up.
// - Edge detection runs only while the I/O clock is running.
// - Power-down wake needs two consecutive low samples at the watchdog tick.
// - Level gone before start-up ends: wake anyway, raise no interrupt.
// - A request needs both the global enable and the channel mask bit.
// - Pins are sampled before edge search; pulses over one clock are caught.
// - An edge or change event sets the channel's flag, bits 2..0.
// - Enabled flagged channel vectors; entering the routine clears the flag.
// - Writing one to a flag bit clears it; writing zero leaves it.
// - A level-sensed channel's flag is held cleared.
// - Mask register holds one enable bit per channel in bits 2..0.
// - Sense register bits 7..0, channel 2 in bits 5..4, channel 0 lowest.
module eip_top
    import eip_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DW-1:0] rd_data,
    input wire logic [NCH-1:0] ext_irq_pins,
    input wire logic global_irq_en,
    input wire logic [NCH-1:0] irq_ack,
    input wire logic io_clk_en,
    input wire logic power_down,
    output logic [NCH-1:0] irq_req,
    output logic wake_req
);

    typedef struct packed {
        logic [7:0] sense;
        logic [NCH-1:0] mask;
        logic [DW-1:0] rd_data;
        logic [NCH-1:0] irq;
        eip_wake_t wstate;
        logic [1:0] hits;
        logic [7:0] wd_cnt;
        logic [8:0] su_cnt;
        logic wake;
    } eip_top_t;

    eip_top_t st_r;
    eip_top_t st_nxt;

    logic [NCH-1:0] pin_s;
    logic [NCH-1:0] flags;
    logic [NCH-1:0] lvl;
    logic [NCH-1:0] flag_clr;
    logic wd_tick;
    logic lvl_wake;
    logic waking;

    eip_sync #(.W(NCH)) u_sync (
        .clock(clock),
        .nrst(nrst),
        .pin(ext_irq_pins),
        .pin_s(pin_s)
    );

    // The pins are observed whatever their direction, so software can
    // drive a pin itself to make an interrupt.
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++)
        begin : g_chan
            eip_chan u_chan (
                .clock(clock),
                .nrst(nrst),
                .pin_s(pin_s[gi]),
                .sense(st_r.sense[2*gi +: 2]),
                .io_clk_en(io_clk_en),
                .flag_clr(flag_clr[gi]),
                .flag(flags[gi]),
                .level_act(lvl[gi])
            );
        end
    endgenerate

    // Flags clear on routine entry or on a written one; the channel gives
    // a coincident event priority over either clear.
    assign flag_clr = irq_ack | ({NCH{wr_en && addr == OFS_FLAGS}}
        & wr_data[FLAG_LSB +: NCH]);

    assign wd_tick = st_r.wd_cnt == 8'(WD_TICK_CYC - 1);
    assign lvl_wake = |(lvl & st_r.mask);
    assign waking = st_r.wstate != W_RUN;

    always_comb
    begin
        st_nxt = st_r;

        if (wr_en)
        begin
            unique case (addr)
                OFS_SENSE: st_nxt.sense = wr_data[SENSE_LSB +: SENSE_W];
                OFS_MASK: st_nxt.mask = wr_data[MASK_LSB +: NCH];
                default: st_nxt.sense = st_r.sense;
            endcase
        end

        st_nxt.rd_data = RDATA_RST;
        if (rd_en)
        begin
            unique case (addr)
                OFS_SENSE: st_nxt.rd_data = st_r.sense;
                OFS_MASK: st_nxt.rd_data = {5'h00, st_r.mask};
                OFS_FLAGS: st_nxt.rd_data = {5'h00, flags};
                OFS_STATUS: st_nxt.rd_data = {4'h0, waking, pin_s};
                default: st_nxt.rd_data = RDATA_RST;
            endcase
        end

        // Level requests wait until start-up is over; a level that left
        // early still woke the part but never reaches the core.
        st_nxt.irq = {NCH{global_irq_en}} & st_r.mask
            & (flags | (lvl & {NCH{!waking}}));

        // Watchdog oscillator stand-in: one tick per nominal period.
        st_nxt.wd_cnt = wd_tick ? 8'h00 : st_r.wd_cnt + 8'h01;

        st_nxt.wake = 1'b0;
        unique case (st_r.wstate)
            W_RUN:
            begin
                st_nxt.hits = 2'h0;
                if (power_down)
                    st_nxt.wstate = W_SAMPLE;
            end
            W_SAMPLE:
            begin
                if (wd_tick)
                begin
                    if (!lvl_wake)
                        st_nxt.hits = 2'h0;
                    else if (st_r.hits == 2'(WAKE_SAMPLES - 1))
                    begin
                        st_nxt.hits = 2'h0;
                        st_nxt.wake = 1'b1;
                        st_nxt.su_cnt = 9'(STARTUP_CYC - 1);
                        st_nxt.wstate = W_START;
                    end
                    else
                        st_nxt.hits = st_r.hits + 2'h1;
                end
                if (!power_down)
                    st_nxt.wstate = W_RUN;
            end
            W_START:
            begin
                st_nxt.wake = 1'b1;
                if (st_r.su_cnt == 9'h000)
                begin
                    st_nxt.wake = 1'b0;
                    st_nxt.wstate = W_RUN;
                end
                else
                    st_nxt.su_cnt = st_r.su_cnt - 9'h001;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            st_r <= '0;
            st_r.sense <= SENSE_RST;
            st_r.mask <= MASK_RST;
            st_r.wstate <= W_RUN;
        end
        else
            st_r <= st_nxt;
    end

    assign rd_data = st_r.rd_data;
    assign irq_req = st_r.irq;
    assign wake_req = st_r.wake;

    a_irq_needs_gie: assert property (@(posedge clock) disable iff (!nrst)
        |irq_req |-> $past(global_irq_en))
        else $error("Request raised without the global enable.");

    a_irq_needs_mask: assert property (@(posedge clock) disable iff (!nrst)
        (irq_req & ~$past(st_r.mask)) == 3'h0)
        else $error("Request raised on a masked channel.");

    a_level_request: assert property (@(posedge clock) disable iff (!nrst)
        global_irq_en && !waking |=> (~irq_req & $past(st_r.mask & lvl)) == 3'h0)
        else $error("Low level on an enabled channel gave no request.");

    a_mask_readback: assert property (@(posedge clock) disable iff (!nrst)
        rd_en && addr == OFS_MASK |=> rd_data == {5'h00, $past(st_r.mask)})
        else $error("Mask register read back wrong.");

    a_sense_readback: assert property (@(posedge clock) disable iff (!nrst)
        wr_en && addr == OFS_SENSE ##1 rd_en && addr == OFS_SENSE
        |=> rd_data == $past(wr_data, 2))
        else $error("Sense register did not keep the written value.");

    a_wake_two_hits: assert property (@(posedge clock) disable iff (!nrst)
        $rose(wake_req) |-> $past(wd_tick) && $past(lvl_wake)
        && $past(st_r.hits) == 2'h1)
        else $error("Wake raised without two consecutive low samples.");

    a_startup_holds: assert property (@(posedge clock) disable iff (!nrst)
        $rose(wake_req) |-> wake_req [*8])
        else $error("Wake request dropped inside the start-up time.");

    a_no_level_in_start: assert property (@(posedge clock) disable iff (!nrst)
        st_r.wstate == W_START && flags == 3'h0 |=> irq_req == 3'h0)
        else $error("Level request raised during start-up.");

    a_ack_clears: assert property (@(posedge clock) disable iff (!nrst)
        irq_ack[1] && st_r.sense[3:2] == SENSE_RISE && !(pin_s[1] && !$past(pin_s[1]))
        |=> !flags[1])
        else $error("Routine entry did not clear the flag.");

endmodule
`default_nettype wire

// file: inc/eip_pkg.sv
// Package of the external pin interrupt unit: register map, field layout,
// reset values, sense encodings, wake states and timing counts.
// Assumes a single 200 MHz clock shared by every file of the unit.
package eip_pkg;

    localparam int NCH = 3;
    localparam int AW = 8;
    localparam int DW = 8;

    // Register offsets on the plain register port.
    localparam logic [7:0] OFS_SENSE = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h01;
    localparam logic [7:0] OFS_FLAGS = 8'h02;
    localparam logic [7:0] OFS_STATUS = 8'h03;

    // Field layout.
    localparam int SENSE_LSB = 0;
    localparam int SENSE_W = 8;
    localparam int MASK_LSB = 0;
    localparam int FLAG_LSB = 0;
    localparam int STAT_PIN_LSB = 0;
    localparam int STAT_WAKE_BIT = 3;

    // Reset values.
    localparam logic [7:0] SENSE_RST = 8'h00;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // Sense selections of one channel.
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_ANY = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;

    // Timing: the watchdog oscillator period and the start-up time.
    localparam int CLK_FREQ_MHZ = 200;
    localparam int WD_PERIOD_US = 1;
    localparam int WD_TICK_CYC = WD_PERIOD_US * CLK_FREQ_MHZ;
    localparam int STARTUP_US = 2;
    localparam int STARTUP_CYC = STARTUP_US * CLK_FREQ_MHZ;
    localparam int WAKE_SAMPLES = 2;

    typedef enum logic [2:0] {
        W_RUN = 3'h1,
        W_SAMPLE = 3'h2,
        W_START = 3'h4
    } eip_wake_t;

endpackage

// file: rtl/eip_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes the pins may change at any time relative to clock.
`timescale 1ns/1ps
`default_nettype none
module eip_sync
    import eip_pkg::*;
#(
    parameter int W = 3
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] pin_s
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } eip_sync_t;

    eip_sync_t st_r;
    eip_sync_t st_nxt;

    // Stage one feeds stage two only, so nothing sees a metastable value.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clock)
    begin
        // Pins idle high behind their pull-ups, so both stages start there;
        // starting low would show a rising edge just after reset.
        if (!nrst)
            st_r <= '1;
        else
            st_r <= st_nxt;
    end

    assign pin_s = st_r.s2;

    a_sync_two_stage: assert property (@(posedge clock) disable iff (!nrst)
        ##2 pin_s == $past(pin, 2))
        else $error("Synchroniser output is not the pin two cycles back.");

endmodule
`default_nettype wire

// file: rtl/eip_chan.sv
// One interrupt channel: edge and change detection and the sticky flag.
// Assumes a synchronised pin level and a one-cycle clear request.
`timescale 1ns/1ps
`default_nettype none
module eip_chan
    import eip_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic pin_s,
    input wire logic [1:0] sense,
    input wire logic io_clk_en,
    input wire logic flag_clr,
    output logic flag,
    output logic level_act
);

    typedef struct packed {
        logic prev;
        logic flag;
    } eip_chan_t;

    eip_chan_t st_r;
    eip_chan_t st_nxt;
    logic evt;

    always_comb
    begin
        st_nxt = st_r;
        evt = 1'b0;
        // Edges are seen only while the I/O clock runs; prev still
        // follows the pin so a resumed clock gives no stale edge.
        unique case (sense)
            SENSE_LOW: evt = 1'b0;
            SENSE_ANY: evt = st_r.prev ^ pin_s;
            SENSE_FALL: evt = st_r.prev & ~pin_s;
            SENSE_RISE: evt = ~st_r.prev & pin_s;
        endcase
        evt = evt & io_clk_en;
        st_nxt.prev = pin_s;
        if (sense == SENSE_LOW)
            st_nxt.flag = 1'b0;
        else if (evt)
            st_nxt.flag = 1'b1;
        else if (flag_clr)
            st_nxt.flag = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        // The previous level starts at the pin's idle high level, so an
        // edge mode written right after reset sees no false edge.
        if (!nrst)
        begin
            st_r <= '0;
            st_r.prev <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign flag = st_r.flag;
    assign level_act = (sense == SENSE_LOW) & ~pin_s;

    a_level_no_flag: assert property (@(posedge clock) disable iff (!nrst)
        sense == SENSE_LOW |=> !flag)
        else $error("Flag set while channel is level sensed.");

    a_event_sets_flag: assert property (@(posedge clock) disable iff (!nrst)
        evt && sense != SENSE_LOW |=> flag)
        else $error("Edge event did not set the flag.");

    a_fall_detect: assert property (@(posedge clock) disable iff (!nrst)
        io_clk_en && sense == SENSE_FALL && $past(pin_s) && !pin_s
        && $past(sense) == SENSE_FALL |=> flag)
        else $error("Falling edge was missed.");

    a_clear_works: assert property (@(posedge clock) disable iff (!nrst)
        flag_clr && !evt |=> !flag)
        else $error("Clear without event left the flag set.");

endmodule
`default_nettype wire

// file: sim/eip_pin_src.sv
// Far-side model: the external sources that drive the three interrupt pins.
// Assumes the bench sets the wanted pin levels just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module eip_pin_src
    import eip_pkg::*;
(
    input wire logic clock,
    input wire logic [NCH-1:0] level,
    output logic [NCH-1:0] ext_irq_pins
);
    // Pins idle high so that the reset sense code of low level stays quiet.
    initial ext_irq_pins = 3'h7;

    // The source moves 2 ns after an edge, so it stays 3 ns clear of the next sample
    // point, and holds every level for at least one whole clock period.
    always @(posedge clock)
    begin
        ext_irq_pins <= #2 level;
    end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench of the external pin interrupt unit.
// Assumes the register map and timing counts of the unit's package.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench;
    import eip_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rd_data;
    logic [2:0] pins;
    logic [2:0] lvl = 3'h7;
    logic global_irq_en = 1'b0;
    logic [2:0] irq_ack = 3'h0;
    logic io_clk_en = 1'b1;
    logic power_down = 1'b0;
    logic [2:0] irq_req;
    logic wake_req;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;

    eip_pin_src u_src (.clock(clock), .level(lvl), .ext_irq_pins(pins));

    eip_top u_dut (.clock(clock), .nrst(nrst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ext_irq_pins(pins),
        .global_irq_en(global_irq_en), .irq_ack(irq_ack), .io_clk_en(io_clk_en),
        .power_down(power_down), .irq_req(irq_req), .wake_req(wake_req));

    initial
    begin
        forever #2.5 clock = ~clock;
    end

    task end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // The wake test needs about 800 cycles; the rest is far shorter.
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            end_sim();
        end
    end

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so look there.
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        `CHK("rd_data", e, rd_data)
    endtask

    task pulse(input int c, input int n);
        @(posedge clock);
        lvl[c] <= ~lvl[c];
        repeat (n) @(posedge clock);
        lvl[c] <= ~lvl[c];
    endtask

    // Index 0 to 2 selects a request bit, index 3 the wake request.
    task wt(input int i, input logic v, input int n);
        logic [3:0] s;
        s = {wake_req, irq_req};
        while (s[i] !== v && n > 0)
        begin
            @(posedge clock);
            #1;
            s = {wake_req, irq_req};
            n--;
        end
        `CHK("request", v, s[i])
    endtask

    // Write and read back with no gap between the two strobes.
    task wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        `CHK("rd_data", e, rd_data)
    endtask

    task ack(input logic [2:0] b);
        @(posedge clock);
        irq_ack <= b;
        @(posedge clock);
        irq_ack <= 3'h0;
    endtask

    initial
    begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        rd(OFS_SENSE, 8'h00);
        rd(OFS_MASK, 8'h00);
        rd(OFS_FLAGS, 8'h00);
        rd(OFS_STATUS, 8'h07);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h00);
        rd(OFS_SENSE, 8'h00);
        // The mask is still clear, so the sense change raises nothing.
        wr_rd(OFS_SENSE, 8'h0e, 8'h0e);
        global_irq_en <= 1'b1;
        wr(OFS_MASK, 8'h03);
        rd(OFS_MASK, 8'h03);
        pulse(0, 2);
        wt(0, 1'b1, 10);
        rd(OFS_FLAGS, 8'h01);
        wr(OFS_FLAGS, 8'h00);
        rd(OFS_FLAGS, 8'h01);
        ack(3'h1);
        wt(0, 1'b0, 4);
        rd(OFS_FLAGS, 8'h00);
        pulse(1, 2);
        wt(1, 1'b1, 10);
        rd(OFS_FLAGS, 8'h02);
        wr(OFS_FLAGS, 8'h02);
        rd(OFS_FLAGS, 8'h00);
        wt(1, 1'b0, 4);
        // Mask off around the sense change so the switch raises nothing.
        wr(OFS_MASK, 8'h00);
        wr(OFS_SENSE, 8'h0d);
        wr(OFS_MASK, 8'h03);
        pulse(0, 2);
        wt(0, 1'b1, 10);
        wr(OFS_FLAGS, 8'h01);
        rd(OFS_FLAGS, 8'h00);
        global_irq_en <= 1'b0;
        pulse(1, 2);
        repeat (8) @(posedge clock);
        #1;
        `CHK("irq_req", 3'h0, irq_req)
        rd(OFS_FLAGS, 8'h02);
        global_irq_en <= 1'b1;
        wt(1, 1'b1, 4);
        ack(3'h2);
        wt(1, 1'b0, 4);
        io_clk_en <= 1'b0;
        pulse(1, 2);
        repeat (6) @(posedge clock);
        io_clk_en <= 1'b1;
        rd(OFS_FLAGS, 8'h00);
        wr(OFS_MASK, 8'h07);
        @(posedge clock);
        lvl[2] <= 1'b0;
        wt(2, 1'b1, 8);
        repeat (20) @(posedge clock);
        #1;
        `CHK("irq_req", 3'h4, irq_req)
        rd(OFS_FLAGS, 8'h00);
        lvl[2] <= 1'b1;
        wt(2, 1'b0, 8);
        power_down <= 1'b1;
        lvl[2] <= 1'b0;
        wt(3, 1'b1, 700);
        // Start-up under way with pin 2 still low: status shows both.
        rd(OFS_STATUS, 8'h0b);
        lvl[2] <= 1'b1;
        wt(3, 1'b0, STARTUP_CYC + 20);
        #1;
        `CHK("irq_req", 3'h0, irq_req)
        power_down <= 1'b0;
        end_sim();
    end
endmodule
`default_nettype wire
